// ---- src/pcacm_ctrl.sv ----
// Operation
// - Overflow flag sets when the counter wraps from FFFF to 0000.
// - Overflow flag stays set; only a software write of zero clears it.
// - Overflow interrupt enable gates the overflow flag onto the interrupt request.
// - Run control zero stops the counter, one lets it count.
// - Five match flags set on module match or capture, cleared by software.
// - Enabled match flag raises the shared interrupt request.
// - Unused control bit 5 and mode bit 4 read zero, writes ignored.
// - Idle suspend set halts counter array while CPU idles.
// - Watchdog enable makes module 4 the watchdog; it resets to one.
// - Once lock is set, watchdog cannot be disabled until reset.
// - Timebase select picks div12, div4, timer0, ext falls, sysclk, ext/8.
// - Divided external clock is synchronised to the system clock first.
// - While watchdog enabled, mode writes leave all other mode bits alone.
// - Control register supports single-bit writes as well as byte writes.
// - Watchdog enabled forces the counter on; run bit reads stored value.
// - Writing one to module 4 flag with watchdog on forces reset.
// - Watchdog reset when low byte wraps while high byte equals compare.
//
// Design decision made here: the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none
module pcacm_ctrl
  import pcacm_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk_i,
  input wire logic reset_i,
  // Register port
  input wire logic [7:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [7:0] rdata_o,
  // Single-bit write port on the control register
  input wire logic bit_wr_i,
  input wire logic [2:0] bit_sel_i,
  input wire logic bit_val_i,
  // Module events and enables
  input wire logic [4:0] match_event_i,
  input wire logic [4:0] match_irq_enable_i,
  input wire logic [7:0] module4_compare_high_i,
  // Timebase sources and system state
  input wire logic cpu_idle_i,
  input wire logic timer0_overflow_i,
  input wire logic external_count_input_i,
  input wire logic external_clock_i,
  // Counter and status
  output logic [15:0] counter_o,
  output logic count_tick_o,
  output logic irq_o,
  output logic watchdog_enable_o,
  output logic watchdog_reset_o
);

  pcacm_ctrl_t ctrl, next_ctrl;
  pcacm_mode_t mode, next_mode;
  logic [15:0] count, next_count;
  logic [3:0] div12, next_div12;
  logic [1:0] div4, next_div4;
  logic [2:0] ext_div, next_ext_div;
  logic ext_sync1, ext_sync2, ext_prev;
  logic eci_prev;
  logic wd_reset, next_wd_reset;
  logic [7:0] rdata, next_rdata;
  logic [7:0] ctrl_mask, ctrl_val;
  logic ctrl_wr, mode_wr;
  logic tick, active, ext_rise, ext_div_tick, eci_fall;

  // Merge a written value into a register under a bit mask
  function automatic logic [7:0] merge(input logic [7:0] cur, input logic [7:0] mask,
                                       input logic [7:0] val);
    merge = (cur & ~mask) | (val & mask);
  endfunction

  // Write decode, byte or single bit
  always_comb begin
    ctrl_wr = (wr_i && addr_i == PCACM_CTRL_ADDR) || bit_wr_i;
    mode_wr = wr_i && addr_i == PCACM_MODE_ADDR;
    if (bit_wr_i) begin
      ctrl_mask = 8'h01 << bit_sel_i;
      ctrl_val = {8{bit_val_i}};
    end else if (ctrl_wr) begin
      ctrl_mask = 8'hFF;
      ctrl_val = wdata_i;
    end else begin
      ctrl_mask = 8'h00;
      ctrl_val = 8'h00;
    end
  end

  // Timebase selection and counter activity
  always_comb begin
    ext_rise = ext_sync2 && !ext_prev;
    ext_div_tick = ext_rise && ext_div == PCACM_EXT_DIV_LAST;
    eci_fall = eci_prev && !external_count_input_i;
    case (mode.timebase_select)
      PCACM_TB_DIV12: tick = div12 == PCACM_DIV12_LAST;
      PCACM_TB_DIV4: tick = div4 == PCACM_DIV4_LAST;
      PCACM_TB_TIMER0: tick = timer0_overflow_i;
      PCACM_TB_EXT_FALL: tick = eci_fall;
      PCACM_TB_SYSCLK: tick = 1'b1;
      PCACM_TB_EXT_DIV8: tick = ext_div_tick;
      default: tick = 1'b0;
    endcase
    active = (ctrl.run_control || mode.watchdog_enable)
             && !(mode.idle_suspend && cpu_idle_i);
  end

  // Dividers and counter next values
  always_comb begin
    next_div12 = (div12 == PCACM_DIV12_LAST) ? 4'h0 : div12 + 4'h1;
    next_div4 = div4 + 2'h1;
    next_ext_div = ext_rise ? ext_div + 3'h1 : ext_div;
    next_count = (active && tick) ? count + 16'h0001 : count;
  end

  // Control register next value
  always_comb begin
    next_ctrl = pcacm_ctrl_t'(merge(ctrl, ctrl_mask, ctrl_val));
    next_ctrl.unused = 1'b0;
    // Hardware set wins over a software clear in the same cycle
    if (active && tick && count == PCACM_COUNT_MAX) begin
      next_ctrl.overflow_flag = 1'b1;
    end
    next_ctrl.match_flags = next_ctrl.match_flags | match_event_i;
  end

  // Mode register next value with watchdog protection
  always_comb begin
    next_mode = mode;
    if (mode_wr) begin
      if (mode.watchdog_enable) begin
        next_mode.watchdog_enable = wdata_i[PCACM_MODE_WDE_BIT] || mode.watchdog_lock;
      end else begin
        next_mode = pcacm_mode_t'(wdata_i);
        next_mode.watchdog_enable = wdata_i[PCACM_MODE_WDE_BIT]
                                    || wdata_i[PCACM_MODE_LOCK_BIT];
      end
    end
    next_mode.unused = 1'b0;
  end

  // Watchdog reset request
  always_comb begin
    next_wd_reset = 1'b0;
    if (mode.watchdog_enable) begin
      if (ctrl_wr && ctrl_mask[PCACM_CTRL_M4_BIT] && ctrl_val[PCACM_CTRL_M4_BIT]) begin
        next_wd_reset = 1'b1;
      end
      if (active && tick && count[7:0] == PCACM_LOW_MAX
          && count[15:8] == module4_compare_high_i) begin
        next_wd_reset = 1'b1;
      end
    end
  end

  // Read data, one cycle after the strobe
  always_comb begin
    next_rdata = 8'h00;
    if (rd_i && addr_i == PCACM_CTRL_ADDR) begin
      next_rdata = ctrl;
    end else if (rd_i && addr_i == PCACM_MODE_ADDR) begin
      next_rdata = mode;
    end
  end

  // State registers
  always_ff @(posedge ref_clk_i or posedge reset_i) begin
    if (reset_i) begin
      ctrl <= pcacm_ctrl_t'(PCACM_CTRL_RESET);
      mode <= pcacm_mode_t'(PCACM_MODE_RESET);
      count <= PCACM_COUNT_RESET;
      div12 <= 4'h0;
      div4 <= 2'h0;
      ext_div <= 3'h0;
      wd_reset <= 1'b0;
      rdata <= 8'h00;
    end else begin
      ctrl <= next_ctrl;
      mode <= next_mode;
      count <= next_count;
      div12 <= next_div12;
      div4 <= next_div4;
      ext_div <= next_ext_div;
      wd_reset <= next_wd_reset;
      rdata <= next_rdata;
    end
  end

  // External clock synchroniser and edge history
  always_ff @(posedge ref_clk_i or posedge reset_i) begin
    if (reset_i) begin
      ext_sync1 <= 1'b0;
      ext_sync2 <= 1'b0;
      ext_prev <= 1'b0;
      eci_prev <= 1'b0;
    end else begin
      ext_sync1 <= external_clock_i;
      ext_sync2 <= ext_sync1;
      ext_prev <= ext_sync2;
      eci_prev <= external_count_input_i;
    end
  end

  // Outputs
  assign rdata_o = rdata;
  assign counter_o = count;
  assign count_tick_o = active && tick;
  assign watchdog_enable_o = mode.watchdog_enable;
  assign watchdog_reset_o = wd_reset;
  assign irq_o = (ctrl.overflow_flag && mode.overflow_irq_enable)
                 || |(ctrl.match_flags & match_irq_enable_i);

  // Checks
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (reset_i);

  sequence s_wrap;
    active && tick && count == PCACM_COUNT_MAX;
  endsequence

  sequence s_flag_seen;
    ctrl.overflow_flag ##1 ctrl.overflow_flag;
  endsequence

  property p_ovf_set;
    s_wrap |=> ctrl.overflow_flag && count == 16'h0000;
  endproperty
  a_ovf_set: assert property (p_ovf_set) else $error("overflow flag not set on wrap");

  property p_ovf_sticky;
    ctrl.overflow_flag && !(ctrl_wr && ctrl_mask[7] && !ctrl_val[7]) |=> ctrl.overflow_flag;
  endproperty
  a_ovf_sticky: assert property (p_ovf_sticky) else $error("overflow flag lost");

  property p_ovf_irq;
    s_flag_seen ##0 mode.overflow_irq_enable |-> irq_o;
  endproperty
  a_ovf_irq: assert property (p_ovf_irq) else $error("overflow irq missing");

  property p_no_irq;
    !(ctrl.overflow_flag && mode.overflow_irq_enable)
    && (ctrl.match_flags & match_irq_enable_i) == 5'h00 |-> !irq_o;
  endproperty
  a_no_irq: assert property (p_no_irq) else $error("spurious irq");

  property p_stopped;
    !ctrl.run_control && !mode.watchdog_enable |=> count == $past(count);
  endproperty
  a_stopped: assert property (p_stopped) else $error("counter moved while stopped");

  property p_match_set;
    match_event_i != 5'h00 |=> (ctrl.match_flags & $past(match_event_i)) == $past(match_event_i);
  endproperty
  a_match_set: assert property (p_match_set) else $error("match flag not set");

  property p_match_irq;
    (ctrl.match_flags & match_irq_enable_i) != 5'h00 |-> irq_o;
  endproperty
  a_match_irq: assert property (p_match_irq) else $error("match irq missing");

  property p_unused_zero;
    rd_i && (addr_i == PCACM_CTRL_ADDR || addr_i == PCACM_MODE_ADDR)
    |=> (($past(addr_i) == PCACM_CTRL_ADDR) ? (rdata_o[PCACM_CTRL_UNUSED_BIT] == 1'b0)
                                            : (rdata_o[PCACM_MODE_UNUSED_BIT] == 1'b0));
  endproperty
  a_unused_zero: assert property (p_unused_zero) else $error("unused bit nonzero");

  property p_idle;
    mode.idle_suspend && cpu_idle_i |=> count == $past(count);
  endproperty
  a_idle: assert property (p_idle) else $error("counter moved in idle");

  property p_lock;
    mode.watchdog_lock |=> mode.watchdog_enable && mode.watchdog_lock;
  endproperty
  a_lock: assert property (p_lock) else $error("locked watchdog disabled");

  property p_sysclk;
    active && mode.timebase_select == PCACM_TB_SYSCLK |=> count == $past(count) + 16'h0001;
  endproperty
  a_sysclk: assert property (p_sysclk) else $error("sysclk timebase miscount");

  property p_frozen;
    mode.watchdog_enable && mode_wr
    |=> mode.timebase_select == $past(mode.timebase_select)
        && mode.idle_suspend == $past(mode.idle_suspend);
  endproperty
  a_frozen: assert property (p_frozen) else $error("mode bits changed under watchdog");

  property p_forced_on;
    mode.watchdog_enable && !cpu_idle_i && tick |=> count == $past(count) + 16'h0001;
  endproperty
  a_forced_on: assert property (p_forced_on) else $error("counter not forced on");

  property p_force_reset;
    mode.watchdog_enable && bit_wr_i && bit_sel_i == 3'h4 && bit_val_i |=> watchdog_reset_o;
  endproperty
  a_force_reset: assert property (p_force_reset) else $error("forced reset missing");

  property p_wd_expire;
    mode.watchdog_enable && active && tick && count[7:0] == 8'hFF
    && count[15:8] == module4_compare_high_i |=> watchdog_reset_o;
  endproperty
  a_wd_expire: assert property (p_wd_expire) else $error("watchdog expiry missed");

endmodule
`default_nettype wire

// ---- src/pcacm_pkg.sv ----
package pcacm_pkg;

  // Register byte addresses
  localparam logic [7:0] PCACM_CTRL_ADDR = 8'hD8;
  localparam logic [7:0] PCACM_MODE_ADDR = 8'hD9;

  // Control register bit positions
  localparam int PCACM_CTRL_OVF_BIT = 7;
  localparam int PCACM_CTRL_RUN_BIT = 6;
  localparam int PCACM_CTRL_UNUSED_BIT = 5;
  localparam int PCACM_CTRL_M4_BIT = 4;

  // Mode register bit positions
  localparam int PCACM_MODE_IDLE_BIT = 7;
  localparam int PCACM_MODE_WDE_BIT = 6;
  localparam int PCACM_MODE_LOCK_BIT = 5;
  localparam int PCACM_MODE_UNUSED_BIT = 4;

  // Values after reset and counter limits
  localparam logic [7:0] PCACM_CTRL_RESET = 8'h00;
  localparam logic [7:0] PCACM_MODE_RESET = 8'h40;
  localparam logic [15:0] PCACM_COUNT_RESET = 16'h0000;
  localparam logic [15:0] PCACM_COUNT_MAX = 16'hFFFF;
  localparam logic [7:0] PCACM_LOW_MAX = 8'hFF;

  // Timebase source codes
  localparam logic [2:0] PCACM_TB_DIV12 = 3'h0;
  localparam logic [2:0] PCACM_TB_DIV4 = 3'h1;
  localparam logic [2:0] PCACM_TB_TIMER0 = 3'h2;
  localparam logic [2:0] PCACM_TB_EXT_FALL = 3'h3;
  localparam logic [2:0] PCACM_TB_SYSCLK = 3'h4;
  localparam logic [2:0] PCACM_TB_EXT_DIV8 = 3'h5;

  // Divider counts in system clock cycles or external edges
  localparam logic [3:0] PCACM_DIV12_LAST = 4'hB;
  localparam logic [1:0] PCACM_DIV4_LAST = 2'h3;
  localparam logic [2:0] PCACM_EXT_DIV_LAST = 3'h7;

  // Control register layout
  typedef struct packed {
    logic overflow_flag;
    logic run_control;
    logic unused;
    logic [4:0] match_flags;
  } pcacm_ctrl_t;

  // Mode register layout
  typedef struct packed {
    logic idle_suspend;
    logic watchdog_enable;
    logic watchdog_lock;
    logic unused;
    logic [2:0] timebase_select;
    logic overflow_irq_enable;
  } pcacm_mode_t;

endpackage

// ---- testbench/tb_pca_counter_control_mode.sv ----
`timescale 1ns/1ps
`default_nettype none
module tb_pca_counter_control_mode;
  import pcacm_pkg::*;
  localparam int WIN = 96;
  logic ref_clk_i = 1'b0;
  logic reset_i, wr_i, rd_i, bit_wr_i, bit_val_i, cpu_idle_i, timer0_overflow_i;
  logic external_count_input_i, external_clock_i, count_tick_o, irq_o;
  logic watchdog_enable_o, watchdog_reset_o;
  logic [7:0] addr_i, wdata_i, rdata_o, module4_compare_high_i;
  logic [2:0] bit_sel_i;
  logic [4:0] match_event_i, match_irq_enable_i;
  logic [15:0] counter_o, d;
  int error_cnt = 0;
  int n_checks = 0;
  int cyc = 0;
  int k, np, nf;

  pcacm_ctrl u_dut (.ref_clk_i(ref_clk_i), .reset_i(reset_i), .addr_i(addr_i),
    .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .bit_wr_i(bit_wr_i),
    .bit_sel_i(bit_sel_i), .bit_val_i(bit_val_i), .match_event_i(match_event_i),
    .match_irq_enable_i(match_irq_enable_i), .module4_compare_high_i(module4_compare_high_i),
    .cpu_idle_i(cpu_idle_i), .timer0_overflow_i(timer0_overflow_i),
    .external_count_input_i(external_count_input_i), .external_clock_i(external_clock_i),
    .counter_o(counter_o), .count_tick_o(count_tick_o), .irq_o(irq_o),
    .watchdog_enable_o(watchdog_enable_o), .watchdog_reset_o(watchdog_reset_o));

  // Clock generation
  always #2.5 ref_clk_i = ~ref_clk_i;

  // Cycle ceiling against hangs
  always @(posedge ref_clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 90000) begin
      error_cnt++;
      tally_and_finish();
    end
  end

  task automatic tally_and_finish();
    if (error_cnt == 0 && n_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  task automatic chk_val(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic chk_bit(input logic got, input logic exp);
    n_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic clocks(input int n);
    repeat (n) @(posedge ref_clk_i);
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    addr_i <= a;
    wdata_i <= v;
    wr_i <= 1'b1;
    @(posedge ref_clk_i);
    wr_i <= 1'b0;
  endtask

  task automatic bw(input logic [2:0] s, input logic v);
    bit_sel_i <= s;
    bit_val_i <= v;
    bit_wr_i <= 1'b1;
    @(posedge ref_clk_i);
    bit_wr_i <= 1'b0;
  endtask

  // Read one register and compare with the expected byte
  task automatic rc(input logic [7:0] a, input logic [7:0] exp);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge ref_clk_i);
    rd_i <= 1'b0;
    #1 chk_val({8'h00, rdata_o}, {8'h00, exp});
  endtask

  task automatic do_reset();
    reset_i <= 1'b1;
    clocks(6);
    reset_i <= 1'b0;
  endtask

  // Ticks expected from one window per timebase code
  function automatic logic [15:0] exp_ticks(input logic [2:0] c, input int p, input int f);
    case (c)
      PCACM_TB_DIV12: return 16'(WIN / 12);
      PCACM_TB_DIV4: return 16'(WIN / 4);
      PCACM_TB_TIMER0: return 16'(p);
      PCACM_TB_EXT_FALL: return 16'(f);
      PCACM_TB_SYSCLK: return 16'(WIN);
      PCACM_TB_EXT_DIV8: return 16'h0002;
      default: return 16'h0000;
    endcase
  endfunction

  // Run the counter for WIN edges while all sources toggle
  task automatic run_win(output logic [15:0] dd, output int p, output int f);
    logic [15:0] c0;
    logic t;
    c0 = counter_o;
    p = 0;
    f = 0;
    // Gap so a preceding write strobe drops before this one rises
    @(posedge ref_clk_i);
    wr(PCACM_CTRL_ADDR, 8'h40);
    for (int i = 0; i < WIN - 1; i++) begin
      t = (i % 3 == 0) && (i < WIN - 8) && (($urandom() & 32'h1) == 32'h1);
      p += int'(t);
      f += int'((i % 8 == 4) && (i < WIN - 8));
      timer0_overflow_i <= t;
      external_count_input_i <= !((i % 8 >= 4) && (i < WIN - 8));
      external_clock_i <= (i < 64) && (i % 4 >= 2);
      @(posedge ref_clk_i);
    end
    timer0_overflow_i <= 1'b0;
    external_count_input_i <= 1'b1;
    external_clock_i <= 1'b0;
    wr(PCACM_CTRL_ADDR, 8'h00);
    clocks(4);
    dd = counter_o - c0;
  endtask

  // Main sequence
  initial begin
    {wr_i, rd_i, bit_wr_i, bit_val_i, cpu_idle_i, timer0_overflow_i} = '0;
    {addr_i, wdata_i, module4_compare_high_i, bit_sel_i} = '0;
    {match_event_i, match_irq_enable_i, external_clock_i} = '0;
    external_count_input_i = 1'b1;
    reset_i = 1'b1;
    void'($urandom(32'hF3D2));
    do_reset();
    rc(PCACM_MODE_ADDR, PCACM_MODE_RESET);
    chk_bit(watchdog_enable_o, 1'b1);
    k = 2;
    while (watchdog_reset_o !== 1'b1 && k < 4000) begin
      @(posedge ref_clk_i);
      #1 k++;
    end
    chk_bit(k >= 3066 && k <= 3080, 1'b1);
    chk_val({8'h00, counter_o[15:8]}, 16'h0001);
    @(posedge ref_clk_i);
    #1 chk_bit(watchdog_reset_o, 1'b0);
    rc(PCACM_CTRL_ADDR, 8'h00);
    wr(PCACM_MODE_ADDR, 8'hBF);
    rc(PCACM_MODE_ADDR, 8'h00);
    wr(PCACM_MODE_ADDR, 8'hFF);
    rc(PCACM_MODE_ADDR, 8'hEF);
    wr(PCACM_MODE_ADDR, 8'h00);
    rc(PCACM_MODE_ADDR, 8'hEF);
    do_reset();
    wr(PCACM_CTRL_ADDR, 8'h10);
    #1 chk_bit(watchdog_reset_o, 1'b1);
    bw(3'h4, 1'b1);
    #1 chk_bit(watchdog_reset_o, 1'b1);
    wr(PCACM_MODE_ADDR, 8'h00);
    #1 chk_bit(watchdog_enable_o, 1'b0);
    wr(PCACM_CTRL_ADDR, 8'h3F);
    rc(PCACM_CTRL_ADDR, 8'h1F);
    chk_bit(irq_o, 1'b0);
    match_irq_enable_i <= 5'h1F;
    @(posedge ref_clk_i);
    #1 chk_bit(irq_o, 1'b1);
    wr(PCACM_CTRL_ADDR, 8'h00);
    rc(8'h00, 8'h00);
    for (int i = 0; i < 5; i++) begin
      match_irq_enable_i <= 5'(1 << i);
      match_event_i <= 5'(1 << i);
      @(posedge ref_clk_i);
      match_event_i <= 5'h00;
      #1 chk_bit(irq_o, 1'b1);
      rc(PCACM_CTRL_ADDR, 8'(1 << i));
      bw(3'(i), 1'b0);
      #1 chk_bit(irq_o, 1'b0);
    end
    bw(3'h6, 1'b1);
    rc(PCACM_CTRL_ADDR, 8'h40);
    bw(3'h6, 1'b0);
    clocks(3);
    d = counter_o;
    clocks(20);
    chk_val(counter_o, d);
    chk_bit(count_tick_o, 1'b0);
    for (int c = 0; c < 8; c++) begin
      wr(PCACM_MODE_ADDR, {4'h0, 3'(c), 1'b0});
      run_win(d, np, nf);
      chk_val(d, exp_ticks(3'(c), np, nf));
    end
    cpu_idle_i <= 1'b1;
    wr(PCACM_MODE_ADDR, 8'h88);
    run_win(d, np, nf);
    chk_val(d, 16'h0000);
    wr(PCACM_MODE_ADDR, 8'h08);
    run_win(d, np, nf);
    chk_val(d, 16'(WIN));
    cpu_idle_i <= 1'b0;
    wr(PCACM_CTRL_ADDR, 8'h40);
    #1 chk_bit(count_tick_o, 1'b1);
    k = 0;
    while (counter_o !== PCACM_COUNT_MAX && k < 70000) begin
      @(posedge ref_clk_i);
      #1 k++;
    end
    @(posedge ref_clk_i);
    #1 chk_val(counter_o, PCACM_COUNT_RESET);
    chk_bit(irq_o, 1'b0);
    clocks(50);
    rc(PCACM_CTRL_ADDR, 8'hC0);
    wr(PCACM_MODE_ADDR, 8'h09);
    #1 chk_bit(irq_o, 1'b1);
    wr(PCACM_CTRL_ADDR, 8'h40);
    #1 chk_bit(irq_o, 1'b0);
    rc(PCACM_CTRL_ADDR, 8'h40);
    tally_and_finish();
  end
endmodule
`default_nettype wire
